// File: sim/frc_core_sva.sv
// port checker for the fault response block
// assumes one clock domain and a synchronous active-low reset
module frc_chk #(
  parameter int P_NUM_CH = 2,
  parameter int P_UNIT_CYC = 500,
  parameter int P_UNITS_PER_MS = 100
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_cmd_valid,
  input wire logic o_cmd_ack,
  input wire logic [15:0] o_cmd_rdata,
  input wire logic [P_NUM_CH-1:0] i_vout_ov,
  input wire logic [P_NUM_CH-1:0] i_run,
  input wire logic [P_NUM_CH-1:0] i_op_on,
  input wire logic [P_NUM_CH-1:0] o_run_out,
  input wire logic [P_NUM_CH-1:0] o_run_oe,
  input wire logic [P_NUM_CH-1:0] o_chan_enable,
  input wire logic [P_NUM_CH-1:0] o_pull_down_only,
  input wire logic o_alert_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD_MIN = 136 * P_UNITS_PER_MS * P_UNIT_CYC;
  logic [31:0] hold_q;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !o_run_oe[0]) begin
      hold_q <= 32'h0;
    end else begin
      hold_q <= hold_q + 32'h1;
    end
  end
  a_ack_follows_cmd: assert property (i_cmd_valid |=> o_cmd_ack) else $error("no ack after command");
  a_ack_has_cause: assert property (o_cmd_ack |-> $past(i_cmd_valid)) else $error("ack without command");
  a_rdata_holds: assert property (!o_cmd_ack |-> $stable(o_cmd_rdata)) else $error("read data moved");
  a_run_drive_low: assert property (o_run_out[0] == 1'b0) else $error("run pin driven high");
  a_hold_starts: assert property ($fell(i_run[0]) |-> ##[1:4] o_run_oe[0]) else $error("hold missing");
  a_hold_min_len: assert property ($fell(o_run_oe[0]) |-> hold_q >= 32'(HOLD_MIN)) else $error("hold short");
  a_hold_output_off: assert property (o_run_oe[0] |-> !o_chan_enable[0]) else $error("on during hold");
  a_on_needs_cmd: assert property ($rose(o_chan_enable[0]) |-> $past(i_op_on[0])) else $error("on uncommanded");
  a_pd_release: assert property ((!i_vout_ov[0]) [*6] |-> !o_pull_down_only[0]) else $error("pull-down stuck");
  c_hold: cover property ($rose(o_run_oe[0]));
  c_alert: cover property ($fell(o_alert_n));
  c_pull_down: cover property ($rose(o_pull_down_only[0]));
endmodule : frc_chk
bind frc_core frc_chk #(.P_NUM_CH(P_NUM_CH), .P_UNIT_CYC(P_UNIT_CYC), .P_UNITS_PER_MS(P_UNITS_PER_MS)) u_chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid), .o_cmd_ack(o_cmd_ack),
  .o_cmd_rdata(o_cmd_rdata), .i_vout_ov(i_vout_ov), .i_run(i_run), .i_op_on(i_op_on), .o_run_out(o_run_out),
  .o_run_oe(o_run_oe), .o_chan_enable(o_chan_enable), .o_pull_down_only(o_pull_down_only), .o_alert_n(o_alert_n));

// File: sim/frc_host_model.sv
// host side model: issues decoded commands to the fault response block
// assumes a one-cycle command strobe and an ack one cycle later
module frc_host_model #(
  parameter int P_PAGE_W = 1
) (
  // clock
  input wire logic i_clk,
  // answer
  input wire logic i_ack,
  input wire logic [15:0] i_rdata,
  // request
  output logic o_valid,
  output logic o_write,
  output logic [P_PAGE_W-1:0] o_page,
  output logic [7:0] o_code,
  output logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ok;
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_page = '0;
    o_code = 8'h00;
    o_wdata = 16'h0000;
    ok = 1'b0;
  end
  // strobe is one cycle: holding it would issue a second command
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [15:0] q);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_write <= w;
    o_code <= c;
    o_wdata <= d;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_wdata <= ~d;
    #1;
    ok = i_ack;
    q = i_rdata;
  endtask : xfer
endmodule : frc_host_model

// File: sim/testbench.sv
// self-checking bench: registers, refusals, fault responses, retry and restart hold
// assumes shortened ticks so that 1 ms is 20 cycles
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 20;
  logic i_clk, i_resetn, i_vin_ov, ack, alert_n, cmd_valid, cmd_write;
  logic [1:0] vout_ov, vout_uv, ton_max, decayed, ramping, run_ext, op_on, run_out, run_oe, en, pd;
  logic [0:0] cmd_page;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rdata, q;
  logic [7:0] ov_codes [5] = '{8'h00, 8'h80, 8'hB8, 8'h47, 8'h78};
  wire logic [1:0] run_pin;
  int n_errors, checks_done, cyc, n;
  // open-drain run pin with pull-up
  assign run_pin = run_ext & ~run_oe;
  frc_host_model u_host (.i_clk(i_clk), .i_ack(ack), .i_rdata(rdata), .o_valid(cmd_valid), .o_write(cmd_write),
    .o_page(cmd_page), .o_code(cmd_code), .o_wdata(cmd_wdata));
  frc_core #(.P_UNIT_CYC(5), .P_UNITS_PER_MS(4)) u_dut (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write), .i_cmd_page(cmd_page), .i_cmd_code(cmd_code),
    .i_cmd_wdata(cmd_wdata), .o_cmd_ack(ack), .o_cmd_rdata(rdata), .i_vin_ov(i_vin_ov), .i_vout_ov(vout_ov),
    .i_vout_uv(vout_uv), .i_ton_max(ton_max), .i_out_decayed(decayed), .i_ramping(ramping), .i_run(run_pin),
    .o_run_out(run_out), .o_run_oe(run_oe), .i_op_on(op_on), .o_chan_enable(en), .o_pull_down_only(pd),
    .o_alert_n(alert_n));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    u_host.xfer(1'b1, c, d, q);
    chk("ack", 16'h1, {15'h0, u_host.ok});
  endtask : wr
  task automatic rdc(input logic [7:0] c, input logic [15:0] m, input logic [15:0] e);
    u_host.xfer(1'b0, c, 16'h0000, q);
    chk("ack", 16'h1, {15'h0, u_host.ok});
    chk($sformatf("code %h", c), e, q & m);
  endtask : rdc
  task automatic cw(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask : cw
  // sel 0 watches enable, sel 1 the run pull-down; n returns cycles waited
  task automatic wait_on(input logic sel, input logic v, input int lim);
    n = 0;
    while (((sel ? run_oe[0] : en[0]) !== v) && n < lim) begin
      cw(1);
      n++;
    end
  endtask : wait_on
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    {i_resetn, i_vin_ov, vout_ov, vout_uv, ton_max, ramping, op_on} = '0;
    decayed = 2'b11;
    run_ext = 2'b11;
    repeat (4) @(posedge i_clk);
    i_resetn <= 1'b1;
    rdc(8'h41, 16'hFFFF, 16'h00B8);
    rdc(8'h45, 16'hFFFF, 16'h00B8);
    rdc(8'h63, 16'hFFFF, 16'h00B8);
    rdc(8'h56, 16'hFFFF, 16'h0080);
    rdc(8'hDB, 16'hFFFF, 16'hFABC);
    wr(8'h41, 16'h0081);
    rdc(8'h41, 16'hFFFF, 16'h00B8);
    rdc(8'h7E, 16'h0040, 16'h0040);
    wr(8'h45, 16'h00C0);
    rdc(8'h45, 16'hFFFF, 16'h00B8);
    cw(2);
    chk("alert_n", 16'h0, {15'h0, alert_n});
    wr(8'hD1, 16'h0010);
    cw(2);
    chk("alert_n", 16'h1, {15'h0, alert_n});
    wr(8'hD1, 16'h0000);
    wr(8'h03, 16'h0000);
    cw(2);
    chk("alert_n", 16'h1, {15'h0, alert_n});
    foreach (ov_codes[i]) begin
      wr(8'h41, {8'h00, ov_codes[i]});
      rdc(8'h41, 16'hFFFF, {8'h00, ov_codes[i]});
    end
    rdc(8'h7E, 16'h0040, 16'h0000);
    wr(8'hDB, 16'h0078);
    wr(8'h41, 16'h0080);
    op_on <= 2'b11;
    wait_on(1'b0, 1'b1, 50);
    vout_ov[0] <= 1'b1;
    cw(6);
    chk("enable", 16'h0, {15'h0, en[0]});
    rdc(8'h78, 16'h0020, 16'h0020);
    rdc(8'h79, 16'h8000, 16'h8000);
    rdc(8'h7A, 16'h0080, 16'h0080);
    chk("alert_n", 16'h0, {15'h0, alert_n});
    vout_ov[0] <= 1'b0;
    cw(200 * MS);
    chk("enable", 16'h0, {15'h0, en[0]});
    rdc(8'h7A, 16'h0080, 16'h0080);
    i_vin_ov <= 1'b1;
    cw(5);
    rdc(8'h7C, 16'h0080, 16'h0080);
    rdc(8'h79, 16'h2001, 16'h2001);
    i_vin_ov <= 1'b0;
    wr(8'h41, 16'h00B8);
    wr(8'h03, 16'h0000);
    op_on <= 2'b00;
    cw(3);
    op_on <= 2'b11;
    wait_on(1'b0, 1'b1, 50);
    chk("enable", 16'h1, {15'h0, en[0]});
    vout_ov[0] <= 1'b1;
    wait_on(1'b0, 1'b0, 10);
    vout_ov[0] <= 1'b0;
    wait_on(1'b0, 1'b1, 200 * MS);
    chk("retry gap", 16'h1, 16'(n > 2390 && n < 2440));
    vout_ov[0] <= 1'b1;
    decayed[0] <= 1'b0;
    wait_on(1'b0, 1'b0, 10);
    vout_ov[0] <= 1'b0;
    cw(130 * MS);
    chk("enable", 16'h0, {15'h0, en[0]});
    decayed[0] <= 1'b1;
    wait_on(1'b0, 1'b1, 20);
    chk("enable", 16'h1, {15'h0, en[0]});
    wr(8'h41, 16'h007B);
    vout_ov[0] <= 1'b1;
    cw(6);
    vout_ov[0] <= 1'b0;
    cw(30);
    chk("enable", 16'h1, {15'h0, en[0]});
    vout_ov[0] <= 1'b1;
    cw(10);
    chk("enable", 16'h1, {15'h0, en[0]});
    wait_on(1'b0, 1'b0, 30);
    chk("enable", 16'h0, {15'h0, en[0]});
    vout_ov[0] <= 1'b0;
    wait_on(1'b0, 1'b1, 200 * MS);
    chk("enable", 16'h1, {15'h0, en[0]});
    wr(8'h41, 16'h0000);
    vout_ov[0] <= 1'b1;
    cw(6);
    chk("pull_down", 16'h1, {15'h0, pd[0]});
    chk("enable", 16'h1, {15'h0, en[0]});
    vout_ov[0] <= 1'b0;
    cw(8);
    chk("pull_down", 16'h0, {15'h0, pd[0]});
    // undervoltage ignored while ramping, acts once the ramp ends
    ramping[0] <= 1'b1;
    vout_uv[0] <= 1'b1;
    cw(6);
    chk("enable", 16'h1, {15'h0, en[0]});
    ramping[0] <= 1'b0;
    wait_on(1'b0, 1'b0, 10);
    chk("enable", 16'h0, {15'h0, en[0]});
    vout_uv[0] <= 1'b0;
    rdc(8'h7A, 16'h0010, 16'h0010);
    wait_on(1'b0, 1'b1, 200 * MS);
    chk("enable", 16'h1, {15'h0, en[0]});
    wr(8'h63, 16'h0000);
    ton_max[0] <= 1'b1;
    cw(6);
    chk("enable", 16'h1, {15'h0, en[0]});
    rdc(8'h7A, 16'h0004, 16'h0000);
    ton_max[0] <= 1'b0;
    // restart time left at 500 ms, rounded up to a 512 ms hold, above off delay + fall + 136 ms
    run_ext[0] <= 1'b0;
    cw(6);
    chk("run_oe", 16'h1, {15'h0, run_oe[0]});
    chk("enable", 16'h0, {15'h0, en[0]});
    run_ext[0] <= 1'b1;
    wait_on(1'b1, 1'b0, 12000);
    chk("hold len", 16'h1, 16'(n > 10220 && n < 10260));
    wait_on(1'b0, 1'b1, 50);
    chk("enable", 16'h1, {15'h0, en[0]});
    wr(8'hD0, 16'h0001);
    decayed[0] <= 1'b0;
    op_on[0] <= 1'b0;
    cw(4);
    op_on[0] <= 1'b1;
    cw(10);
    chk("enable", 16'h0, {15'h0, en[0]});
    decayed[0] <= 1'b1;
    wait_on(1'b0, 1'b1, 20);
    chk("enable", 16'h1, {15'h0, en[0]});
    conclude();
  end
endmodule : testbench

// File: src/frc_core.sv
// per-channel fault response, retry and restart hold sequencing
// assumes a decoded command port (code, page, data) from the serial front end
// and asynchronous comparator and pin levels, which are synchronised here
`include "frc_params.svh"
module frc_core
  import frc_pkg::*;
#(
  parameter int P_NUM_CH = 2,
  parameter int P_PAGE_W = 1,
  parameter int P_UNIT_CYC = `FRC_UNIT_CYC,
  parameter int P_UNITS_PER_MS = `FRC_UNITS_PER_MS
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // command port
  input wire logic i_cmd_valid,
  input wire logic i_cmd_write,
  input wire logic [P_PAGE_W-1:0] i_cmd_page,
  input wire logic [7:0] i_cmd_code,
  input wire logic [15:0] i_cmd_wdata,
  output logic o_cmd_ack,
  output logic [15:0] o_cmd_rdata,
  // comparator levels
  input wire logic i_vin_ov,
  input wire logic [P_NUM_CH-1:0] i_vout_ov,
  input wire logic [P_NUM_CH-1:0] i_vout_uv,
  input wire logic [P_NUM_CH-1:0] i_ton_max,
  input wire logic [P_NUM_CH-1:0] i_out_decayed,
  input wire logic [P_NUM_CH-1:0] i_ramping,
  // run pins, open drain
  input wire logic [P_NUM_CH-1:0] i_run,
  output logic [P_NUM_CH-1:0] o_run_out,
  output logic [P_NUM_CH-1:0] o_run_oe,
  // channel control
  input wire logic [P_NUM_CH-1:0] i_op_on,
  output logic [P_NUM_CH-1:0] o_chan_enable,
  output logic [P_NUM_CH-1:0] o_pull_down_only,
  output logic o_alert_n
);

  // linear word to whole ms, negative values read as zero, saturating
  function automatic logic [16:0] frc_l11_ms(input logic [15:0] w);
    logic [4:0] ex;
    logic [33:0] wide;
    ex = w[15:11];
    wide = 34'h0;
    if (!w[10]) begin
      if (!ex[4]) begin
        wide = {23'h0, w[10:0]} << ex[3:0];
      end else begin
        wide = {23'h0, w[10:0]} >> (5'h00 - ex);
      end
    end
    frc_l11_ms = (wide[33:17] != 17'h0) ? 17'h1FFFF : wide[16:0];
  endfunction : frc_l11_ms

  function automatic logic [16:0] frc_clamp(input logic [16:0] v, input logic [16:0] lo, input logic [16:0] hi);
    frc_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : frc_clamp

  // only these output overvoltage responses are accepted
  function automatic logic frc_ov_ok(input logic [7:0] r);
    frc_ov_ok = (r == 8'h00) || (r == 8'h80) || (r == 8'hB8) || (r[7:3] == 5'h08) || (r[7:3] == 5'h0F);
  endfunction : frc_ov_ok

  // input synchronisers; the first stage feeds only the second
  localparam int SW = 5 * P_NUM_CH + 1;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {i_vin_ov, i_vout_ov, i_vout_uv, i_ton_max, i_out_decayed, i_run};
      sync2_q <= sync1_q;
    end
  end
  logic vin_s;
  logic [P_NUM_CH-1:0] ov_s;
  logic [P_NUM_CH-1:0] uv_s;
  logic [P_NUM_CH-1:0] ton_s;
  logic [P_NUM_CH-1:0] dec_s;
  logic [P_NUM_CH-1:0] run_s;
  assign {vin_s, ov_s, uv_s, ton_s, dec_s, run_s} = sync2_q;
  // ramping comes from the ramp generator on this clock
  logic [P_NUM_CH-1:0] ramp_s;
  assign ramp_s = i_ramping;

  // 10 us enable divider
  logic [15:0] div_q;
  logic tick;
  assign tick = (div_q == 16'(P_UNIT_CYC - 1));
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= tick ? 16'h0000 : div_q + 16'h0001;
    end
  end

  // command decode and global status
  logic cmd_wr;
  logic clear_all;
  logic bad_wr;
  assign cmd_wr = i_cmd_valid && i_cmd_write;
  assign clear_all = cmd_wr && (i_cmd_code == `FRC_CODE_CLEAR);
  always_comb begin
    bad_wr = 1'b0;
    if (cmd_wr) begin
      case (i_cmd_code)
        `FRC_CODE_OV_RESP: bad_wr = !frc_ov_ok(i_cmd_wdata[7:0]);
        `FRC_CODE_UV_RESP, `FRC_CODE_VIN_RESP, `FRC_CODE_TON_RESP: bad_wr = (i_cmd_wdata[7:6] == 2'b11);
        default: bad_wr = 1'b0;
      endcase
    end
  end

  logic cml_q;
  logic vin_st_q;
  logic [7:0] mask_q;
  // set wins over the clear command
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cml_q <= 1'b0;
    end else begin
      cml_q <= bad_wr | (cml_q & ~clear_all);
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      vin_st_q <= 1'b0;
    end else begin
      vin_st_q <= vin_s | (vin_st_q & ~clear_all);
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      mask_q <= `FRC_RST_MASK;
    end else if (cmd_wr && i_cmd_code == `FRC_CODE_MASK) begin
      mask_q <= i_cmd_wdata[7:0];
    end
  end

  // per-channel views for the read mux and alert
  logic [P_NUM_CH-1:0][7:0] ov_resp_w;
  logic [P_NUM_CH-1:0][7:0] uv_resp_w;
  logic [P_NUM_CH-1:0][7:0] vin_resp_w;
  logic [P_NUM_CH-1:0][7:0] ton_resp_w;
  logic [P_NUM_CH-1:0][7:0] cfg_w;
  logic [P_NUM_CH-1:0][15:0] retry_w;
  logic [P_NUM_CH-1:0][15:0] restart_w;
  logic [P_NUM_CH-1:0] ov_st_w;
  logic [P_NUM_CH-1:0] uv_st_w;
  logic [P_NUM_CH-1:0] ton_st_w;

  genvar g;
  generate
    for (g = 0; g < P_NUM_CH; g = g + 1) begin : g_ch
      logic [7:0] ov_resp_q;
      logic [7:0] uv_resp_q;
      logic [7:0] vin_resp_q;
      logic [7:0] ton_resp_q;
      logic [7:0] cfg_q;
      logic [15:0] retry_q;
      logic [15:0] restart_q;
      logic ov_st_q;
      logic uv_st_q;
      logic ton_st_q;
      logic on_prev_q;
      logic run_prev_q;
      logic pd_q;
      frc_state_t state_q;
      frc_src_t src_q;
      logic [7:0] act_q;
      logic [2:0] degl_q;
      logic [7:0] unit_q;
      logic [16:0] ms_q;
      logic wr_me;
      logic on_cmd;
      logic on_rise;
      logic run_fall;
      logic clr_ch;
      logic uv_arm;
      logic [3:0] cond;
      logic hit;
      frc_src_t hit_src;
      logic [7:0] hit_resp;
      logic [16:0] retry_ms;
      logic [16:0] restart_ms;
      logic [16:0] rst_c;
      logic decay_ok_retry;
      logic timing;

      assign wr_me = cmd_wr && (i_cmd_page == P_PAGE_W'(g)) && !bad_wr;
      assign on_cmd = i_op_on[g] && run_s[g];
      assign on_rise = on_cmd && !on_prev_q;
      assign run_fall = run_prev_q && !run_s[g];
      assign clr_ch = clear_all || on_rise;
      assign uv_arm = (state_q == ST_ON || state_q == ST_DEGL) && !ramp_s[g];
      assign cond = {uv_s[g] && uv_arm, ton_s[g] && (ton_resp_q != 8'h00), vin_s, ov_s[g]};

      // paged response registers, refused writes leave them untouched
      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          ov_resp_q <= `FRC_RST_OV;
          uv_resp_q <= `FRC_RST_UV;
          vin_resp_q <= `FRC_RST_VIN;
          ton_resp_q <= `FRC_RST_TON;
          cfg_q <= `FRC_RST_CFG;
          retry_q <= `FRC_RST_RETRY;
          restart_q <= `FRC_RST_RESTART;
        end else if (wr_me) begin
          case (i_cmd_code)
            `FRC_CODE_OV_RESP: ov_resp_q <= i_cmd_wdata[7:0];
            `FRC_CODE_UV_RESP: uv_resp_q <= i_cmd_wdata[7:0];
            `FRC_CODE_VIN_RESP: vin_resp_q <= i_cmd_wdata[7:0];
            `FRC_CODE_TON_RESP: ton_resp_q <= i_cmd_wdata[7:0];
            `FRC_CODE_CFG: cfg_q <= i_cmd_wdata[7:0];
            `FRC_CODE_RETRY: retry_q <= i_cmd_wdata;
            `FRC_CODE_RESTART: restart_q <= i_cmd_wdata;
            default: cfg_q <= cfg_q;
          endcase
        end
      end

      // sticky status, set wins over clear
      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          ov_st_q <= 1'b0;
          uv_st_q <= 1'b0;
          ton_st_q <= 1'b0;
        end else begin
          ov_st_q <= cond[0] | (ov_st_q & ~clr_ch);
          ton_st_q <= cond[2] | (ton_st_q & ~clr_ch);
          uv_st_q <= cond[3] | (uv_st_q & ~clr_ch);
        end
      end

      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          on_prev_q <= 1'b0;
          run_prev_q <= 1'b0;
        end else begin
          on_prev_q <= on_cmd;
          run_prev_q <= run_s[g];
        end
      end

      // highest priority fault whose response acts on the output
      always_comb begin
        hit = 1'b0;
        hit_src = SRC_OV;
        hit_resp = 8'h00;
        if (cond[0] && ov_resp_q[7:6] != 2'b00) begin
          hit = 1'b1;
          hit_resp = ov_resp_q;
        end else if (cond[1] && vin_resp_q[7:6] != 2'b00) begin
          hit = 1'b1;
          hit_src = SRC_VIN;
          hit_resp = vin_resp_q;
        end else if (cond[2] && ton_resp_q[7:6] != 2'b00) begin
          hit = 1'b1;
          hit_src = SRC_TON;
          hit_resp = ton_resp_q;
        end else if (cond[3] && uv_resp_q[7:6] != 2'b00) begin
          hit = 1'b1;
          hit_src = SRC_UV;
          hit_resp = uv_resp_q;
        end
      end

      assign retry_ms = frc_clamp(frc_l11_ms(retry_q), `FRC_RETRY_MIN_MS, `FRC_RETRY_MAX_MS);
      assign rst_c = frc_clamp(frc_l11_ms(restart_q), `FRC_RESTART_MIN_MS, `FRC_RESTART_MAX_MS);
      // round up to the 16 ms step so the hold is never short
      assign restart_ms = {rst_c[16:4], 4'h0} + ((rst_c[3:0] != 4'h0) ? 17'h00010 : 17'h00000);
      assign decay_ok_retry = cfg_q[`FRC_CFG_DECAY] || dec_s[g];
      assign timing = (state_q == ST_DEGL) || (state_q == ST_RETRY) || (state_q == ST_HOLD);

      // ms timer, cleared on fault detection and on hold entry
      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          unit_q <= 8'h00;
          ms_q <= 17'h00000;
        end else if ((state_q == ST_ON && hit) || (state_q != ST_HOLD && run_fall)) begin
          unit_q <= 8'h00;
          ms_q <= 17'h00000;
        end else if (timing && tick) begin
          if (unit_q == 8'(P_UNITS_PER_MS - 1)) begin
            unit_q <= 8'h00;
            ms_q <= (ms_q == 17'h1FFFF) ? ms_q : ms_q + 17'h00001;
          end else begin
            unit_q <= unit_q + 8'h01;
          end
        end
      end

      // deglitch count in 10 us units
      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          degl_q <= 3'h0;
        end else if (state_q != ST_DEGL) begin
          degl_q <= 3'h0;
        end else if (tick && degl_q != 3'h7) begin
          degl_q <= degl_q + 3'h1;
        end
      end

      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          state_q <= ST_OFF;
          src_q <= SRC_OV;
          act_q <= 8'h00;
        end else if (state_q != ST_HOLD && run_fall) begin
          state_q <= ST_HOLD;
        end else begin
          case (state_q)
            ST_OFF: begin
              if (on_cmd && (!cfg_q[`FRC_CFG_DECAY] || dec_s[g])) begin
                state_q <= ST_ON;
              end
            end
            ST_ON: begin
              if (!on_cmd) begin
                state_q <= ST_OFF;
              end else if (hit) begin
                src_q <= hit_src;
                act_q <= hit_resp;
                if (hit_resp[7:6] == 2'b01) begin
                  state_q <= ST_DEGL;
                end else begin
                  state_q <= (hit_resp[5:3] == 3'b111) ? ST_RETRY : ST_LATCH;
                end
              end
            end
            ST_DEGL: begin
              if (!on_cmd) begin
                state_q <= ST_OFF;
              end else if (!cond[src_q]) begin
                state_q <= ST_ON;
              end else if (degl_q >= act_q[2:0]) begin
                state_q <= (act_q[5:3] == 3'b111) ? ST_RETRY : ST_LATCH;
              end
            end
            ST_RETRY: begin
              if (!on_cmd) begin
                state_q <= ST_OFF;
              end else if (ms_q >= retry_ms && decay_ok_retry) begin
                state_q <= ST_ON;
              end
            end
            ST_LATCH: begin
              if (!on_cmd) begin
                state_q <= ST_OFF;
              end
            end
            ST_HOLD: begin
              if (ms_q >= restart_ms) begin
                state_q <= ST_OFF;
              end
            end
            default: state_q <= ST_OFF;
          endcase
        end
      end

      // bottom switch on while the output stays above the limit and the overvoltage response is 00
      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          pd_q <= 1'b0;
        end else begin
          pd_q <= ov_s[g] && (ov_resp_q == 8'h00);
        end
      end

      assign o_chan_enable[g] = (state_q == ST_ON) || (state_q == ST_DEGL);
      assign o_pull_down_only[g] = pd_q;
      assign o_run_out[g] = 1'b0;
      assign o_run_oe[g] = (state_q == ST_HOLD);
      assign ov_resp_w[g] = ov_resp_q;
      assign uv_resp_w[g] = uv_resp_q;
      assign vin_resp_w[g] = vin_resp_q;
      assign ton_resp_w[g] = ton_resp_q;
      assign cfg_w[g] = cfg_q;
      assign retry_w[g] = retry_q;
      assign restart_w[g] = restart_q;
      assign ov_st_w[g] = ov_st_q;
      assign uv_st_w[g] = uv_st_q;
      assign ton_st_w[g] = ton_st_q;
    end
  endgenerate

  // status views of the addressed page
  logic [7:0] sb;
  logic [7:0] sv;
  logic [15:0] sw;
  always_comb begin
    sv = 8'h00;
    sv[`FRC_SV_OV] = ov_st_w[i_cmd_page];
    sv[`FRC_SV_UV] = uv_st_w[i_cmd_page];
    sv[`FRC_SV_TON] = ton_st_w[i_cmd_page];
    sb = 8'h00;
    sb[`FRC_SB_VOUT_OV] = ov_st_w[i_cmd_page];
    sb[`FRC_SB_CML] = cml_q;
    sb[`FRC_SB_NONE] = vin_st_w_any() | uv_st_w[i_cmd_page] | ton_st_w[i_cmd_page];
    sw = {8'h00, sb};
    sw[`FRC_SW_VOUT] = |sv;
    sw[`FRC_SW_INPUT] = vin_st_q;
  end

  function automatic logic vin_st_w_any();
    vin_st_w_any = vin_st_q;
  endfunction : vin_st_w_any

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_cmd_ack <= 1'b0;
      o_cmd_rdata <= 16'h0000;
    end else begin
      o_cmd_ack <= i_cmd_valid;
      if (i_cmd_valid && !i_cmd_write) begin
        case (i_cmd_code)
          `FRC_CODE_OV_RESP: o_cmd_rdata <= {8'h00, ov_resp_w[i_cmd_page]};
          `FRC_CODE_UV_RESP: o_cmd_rdata <= {8'h00, uv_resp_w[i_cmd_page]};
          `FRC_CODE_VIN_RESP: o_cmd_rdata <= {8'h00, vin_resp_w[i_cmd_page]};
          `FRC_CODE_TON_RESP: o_cmd_rdata <= {8'h00, ton_resp_w[i_cmd_page]};
          `FRC_CODE_CFG: o_cmd_rdata <= {8'h00, cfg_w[i_cmd_page]};
          `FRC_CODE_MASK: o_cmd_rdata <= {8'h00, mask_q};
          `FRC_CODE_RETRY: o_cmd_rdata <= retry_w[i_cmd_page];
          `FRC_CODE_RESTART: o_cmd_rdata <= restart_w[i_cmd_page];
          `FRC_CODE_STAT_BYTE: o_cmd_rdata <= {8'h00, sb};
          `FRC_CODE_STAT_WORD: o_cmd_rdata <= sw;
          `FRC_CODE_STAT_VOUT: o_cmd_rdata <= {8'h00, sv};
          `FRC_CODE_STAT_INPUT: o_cmd_rdata <= {8'h00, vin_st_q, 7'h00};
          `FRC_CODE_STAT_CML: o_cmd_rdata <= {9'h000, cml_q, 6'h00};
          default: o_cmd_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // alert from any unmasked sticky fault of any page
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_alert_n <= 1'b1;
    end else begin
      o_alert_n <= !((vin_st_q && !mask_q[`FRC_MK_VIN]) || (|ov_st_w && !mask_q[`FRC_MK_OV]) ||
                     (|uv_st_w && !mask_q[`FRC_MK_UV]) || (|ton_st_w && !mask_q[`FRC_MK_TON]) ||
                     (cml_q && !mask_q[`FRC_MK_CML]));
    end
  end

endmodule : frc_core

// File: src/frc_params.svh
// constants for the per-channel fault response and retry block
// assumes a 50 MHz core clock and an already decoded command port
`ifndef FRC_PARAMS_SVH
`define FRC_PARAMS_SVH
// command codes
`define FRC_CODE_CLEAR 8'h03
`define FRC_CODE_OV_RESP 8'h41
`define FRC_CODE_UV_RESP 8'h45
`define FRC_CODE_VIN_RESP 8'h56
`define FRC_CODE_TON_RESP 8'h63
`define FRC_CODE_STAT_BYTE 8'h78
`define FRC_CODE_STAT_WORD 8'h79
`define FRC_CODE_STAT_VOUT 8'h7A
`define FRC_CODE_STAT_INPUT 8'h7C
`define FRC_CODE_STAT_CML 8'h7E
`define FRC_CODE_CFG 8'hD0
`define FRC_CODE_MASK 8'hD1
`define FRC_CODE_RETRY 8'hDB
`define FRC_CODE_RESTART 8'hDC
// reset values
`define FRC_RST_OV 8'hB8
`define FRC_RST_UV 8'hB8
`define FRC_RST_VIN 8'h80
`define FRC_RST_TON 8'hB8
`define FRC_RST_RETRY 16'hFABC
`define FRC_RST_RESTART 16'hFBE8
`define FRC_RST_CFG 8'h00
`define FRC_RST_MASK 8'h00
// status bit positions
`define FRC_SB_VOUT_OV 5
`define FRC_SB_CML 1
`define FRC_SB_NONE 0
`define FRC_SW_VOUT 15
`define FRC_SW_INPUT 13
`define FRC_SV_OV 7
`define FRC_SV_UV 4
`define FRC_SV_TON 2
`define FRC_SI_VIN_OV 7
`define FRC_SC_DATA 6
// mask bit positions
`define FRC_MK_VIN 0
`define FRC_MK_OV 1
`define FRC_MK_UV 2
`define FRC_MK_TON 3
`define FRC_MK_CML 4
// configuration bit
`define FRC_CFG_DECAY 0
// timing
`define FRC_CLK_MHZ 50
`define FRC_UNIT_US 10
`define FRC_MS_US 1000
`define FRC_UNIT_CYC ((`FRC_UNIT_US) * (`FRC_CLK_MHZ))
`define FRC_UNITS_PER_MS ((`FRC_MS_US) / (`FRC_UNIT_US))
`define FRC_RESTART_MIN_MS 17'h00088
`define FRC_RESTART_MAX_MS 17'h0FFF0
`define FRC_RETRY_MIN_MS 17'h00078
`define FRC_RETRY_MAX_MS 17'h147A8
`endif

// File: src/frc_pkg.sv
// types of the fault response and retry block
// assumes frc_params.svh carries every number
package frc_pkg;
  typedef enum logic [5:0] {
    ST_OFF = 6'b000001,
    ST_ON = 6'b000010,
    ST_DEGL = 6'b000100,
    ST_RETRY = 6'b001000,
    ST_LATCH = 6'b010000,
    ST_HOLD = 6'b100000
  } frc_state_t;
  // fault source index, priority order
  typedef enum logic [1:0] {
    SRC_OV = 2'h0,
    SRC_VIN = 2'h1,
    SRC_TON = 2'h2,
    SRC_UV = 2'h3
  } frc_src_t;
endpackage : frc_pkg
